//--- saf_status_alert.sv
// status summary and channel 0 to 3 alert register bank
`timescale 1ns/1ps
`include "saf_defs.svh"

// What this block does
// RULE1: status bit 2 reads as the OR of every interface error bit.
// RULE2: status bit 1 sets whenever any of the sixteen overvoltage clamp flags is high.
// RULE3: status bit 1 holds and is cleared by a read only if no clamp flag is high then.
// RULE4: the threshold alert summary reads 1 when any upper or lower alert is set.
// RULE5: a channel 0..3 lower alert sets when a result is at or below its lower threshold.
// RULE6: a channel 0..3 upper alert sets when a result is at or above its upper threshold.
// RULE7: alert bits of a channel set from results only while its detection is enabled; auto-clear acts whether it is enabled or not.
// RULE8: reading the alert register clears the alert bits it holds.
// RULE9: with auto-clear selected, a later result back inside the band by the hysteresis margin clears a set alert bit.
// RULE10: the channel 0..3 alert register sits at 0x0015 and resets to zero.
// RULE11: the alert summary is status bit 3, not sticky, over channels 0 to 15.
// RULE12: a set condition in the same cycle as a clearing read wins.

module saf_status_alert
    import saf_pkg::*;
(
    input  wire logic                        clk_i,
    input  wire logic                        rst_n_i,
    input  wire logic                        rd_en_i,
    input  wire logic [`SAF_ADDR_W-1:0]      rd_addr_i,
    input  wire logic [`SAF_IFERR_W-1:0]     iface_err_i,
    input  wire logic [`SAF_NUM_INPUTS-1:0]  per_input_overvoltage_flag_i,
    input  wire logic [`SAF_EXT_ALERT_W-1:0] ext_alert_i,
    input  wire logic                        conv_valid_i,
    input  wire logic [3:0]                  conv_ch_i,
    input  wire saf_word_t                   conv_result_i,
    input  wire saf_word_t                   upper_thr_i [`SAF_NUM_CH],
    input  wire saf_word_t                   lower_thr_i [`SAF_NUM_CH],
    input  wire saf_word_t                   hyst_i      [`SAF_NUM_CH],
    input  wire logic [`SAF_NUM_CH-1:0]      det_en_i,
    input  wire logic                        alert_auto_clr_i,
    output logic [7:0]                       rd_data_o,
    output logic                             rd_valid_o,
    output logic [7:0]                       status_o,
    output logic [7:0]                       alert_flags_ch0_to_3_o
);

    saf_sel_t                rd_sel;
    logic                    rd_alert;
    logic                    rd_status;
    logic                    clamp_q;
    logic                    clamp_d;
    logic [7:0]              rd_data_q;
    logic [7:0]              rd_data_d;
    logic                    rd_valid_q;
    logic                    rd_valid_d;
    logic [7:0]              status_q;
    logic [7:0]              status_d;
    logic [7:0]              status_live;
    logic [7:0]              alert_flags_ch0_to_3;
    logic [`SAF_NUM_CH-1:0]  upper_alert;
    logic [`SAF_NUM_CH-1:0]  lower_alert;

    // ------------------------------------------------------------------------
    // read decode
    // ------------------------------------------------------------------------
    always_comb begin
        rd_sel = SAF_SEL_NONE;
        if (rd_en_i && (rd_addr_i == `SAF_ADDR_STATUS)) begin
            rd_sel = SAF_SEL_STATUS;
        end else if (rd_en_i && (rd_addr_i == `SAF_ADDR_ALERT1)) begin
            rd_sel = SAF_SEL_ALERT; // RULE10
        end
        rd_status = (rd_sel == SAF_SEL_STATUS);
        rd_alert  = (rd_sel == SAF_SEL_ALERT);
    end

    // ------------------------------------------------------------------------
    // per-channel alert flags
    // ------------------------------------------------------------------------
    for (genvar c = 0; c < `SAF_NUM_CH; c++) begin : g_ch
        saf_chan_alert u_chan (
            .clk_i        (clk_i),
            .rst_n_i      (rst_n_i),
            .conv_valid_i (conv_valid_i && (conv_ch_i == 4'(c))),
            .result_i     (conv_result_i),
            .upper_thr_i  (upper_thr_i[c]),
            .lower_thr_i  (lower_thr_i[c]),
            .hyst_i       (hyst_i[c]),
            .det_en_i     (det_en_i[c]),
            .auto_clr_i   (alert_auto_clr_i),
            .rd_clr_i     (rd_alert),
            .upper_o      (upper_alert[c]),
            .lower_o      (lower_alert[c])
        );
        assign alert_flags_ch0_to_3[2*c]   = upper_alert[c]; // RULE6
        assign alert_flags_ch0_to_3[2*c+1] = lower_alert[c]; // RULE5
    end

    // ------------------------------------------------------------------------
    // summary bits and read data
    // ------------------------------------------------------------------------
    always_comb begin
        clamp_d = clamp_q;
        if (rd_status && !(|per_input_overvoltage_flag_i)) begin
            clamp_d = 1'b0; // RULE3
        end
        if (|per_input_overvoltage_flag_i) begin
            clamp_d = 1'b1; // RULE2 RULE12
        end

        status_live = `SAF_STATUS_RST;
        status_live[`SAF_ST_TDA_BIT]   = (|alert_flags_ch0_to_3) | (|ext_alert_i); // RULE4 RULE11
        status_live[`SAF_ST_IFERR_BIT] = |iface_err_i; // RULE1
        status_live[`SAF_ST_CLAMP_BIT] = clamp_q | (|per_input_overvoltage_flag_i); // RULE2
        status_d = status_live;

        rd_valid_d = rd_en_i;
        rd_data_d  = `SAF_RDATA_RST;
        unique case (rd_sel)
            SAF_SEL_NONE:   rd_data_d = `SAF_RDATA_RST;
            SAF_SEL_STATUS: rd_data_d = status_live;
            SAF_SEL_ALERT:  rd_data_d = alert_flags_ch0_to_3;
        endcase
    end

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            clamp_q    <= 1'b0;
            status_q   <= `SAF_STATUS_RST;
            rd_data_q  <= `SAF_RDATA_RST;
            rd_valid_q <= 1'b0;
        end else begin
            clamp_q    <= clamp_d;
            status_q   <= status_d;
            rd_data_q  <= rd_data_d;
            rd_valid_q <= rd_valid_d;
        end
    end

    assign rd_data_o              = rd_data_q;
    assign rd_valid_o             = rd_valid_q;
    assign status_o               = status_q;
    assign alert_flags_ch0_to_3_o = alert_flags_ch0_to_3;

endmodule : saf_status_alert

//--- saf_defs.svh
// offsets, field positions, reset values and sizes of the status and alert flag bank
`ifndef SAF_DEFS_SVH
`define SAF_DEFS_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define SAF_ADDR_W          16
`define SAF_ADDR_STATUS     16'h0014
`define SAF_ADDR_ALERT1     16'h0015

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define SAF_STATUS_RST      8'h00
`define SAF_ALERT1_RST      8'h00
`define SAF_RDATA_RST       8'h00

// ----------------------------------------------------------------------------
// status register field positions
// ----------------------------------------------------------------------------
`define SAF_ST_TDA_BIT      3
`define SAF_ST_IFERR_BIT    2
`define SAF_ST_CLAMP_BIT    1

// ----------------------------------------------------------------------------
// sizes
// ----------------------------------------------------------------------------
`define SAF_NUM_CH          4
`define SAF_NUM_INPUTS      16
`define SAF_EXT_ALERT_W     24
`define SAF_IFERR_W         8
`define SAF_RES_W           16

`endif

//--- saf_pkg.sv
// types and shared arithmetic of the status and alert flag bank
`include "saf_defs.svh"

package saf_pkg;

    typedef logic [`SAF_RES_W-1:0] saf_word_t;

    typedef enum logic [1:0] {
        SAF_SEL_NONE,
        SAF_SEL_STATUS,
        SAF_SEL_ALERT
    } saf_sel_t;

    // saturating add, clamps at full scale
    function automatic saf_word_t saf_sat_add(input saf_word_t a, input saf_word_t b);
        logic [`SAF_RES_W:0] s;
        s = {1'b0, a} + {1'b0, b};
        saf_sat_add = s[`SAF_RES_W] ? {`SAF_RES_W{1'b1}} : s[`SAF_RES_W-1:0];
    endfunction : saf_sat_add

    // saturating subtract, clamps at zero
    function automatic saf_word_t saf_sat_sub(input saf_word_t a, input saf_word_t b);
        saf_sat_sub = (a > b) ? saf_word_t'(a - b) : '0;
    endfunction : saf_sat_sub

endpackage : saf_pkg

//--- saf_chan_alert.sv
// upper and lower threshold alert flags of one channel
`timescale 1ns/1ps

module saf_chan_alert
    import saf_pkg::*;
(
    input  wire logic      clk_i,
    input  wire logic      rst_n_i,
    input  wire logic      conv_valid_i,
    input  wire saf_word_t result_i,
    input  wire saf_word_t upper_thr_i,
    input  wire saf_word_t lower_thr_i,
    input  wire saf_word_t hyst_i,
    input  wire logic      det_en_i,
    input  wire logic      auto_clr_i,
    input  wire logic      rd_clr_i,
    output logic           upper_o,
    output logic           lower_o
);

    logic upper_q;
    logic upper_d;
    logic lower_q;
    logic lower_d;
    logic upper_set;
    logic lower_set;
    logic upper_back;
    logic lower_back;

    // ------------------------------------------------------------------------
    // next flag values
    // ------------------------------------------------------------------------
    always_comb begin
        upper_set  = conv_valid_i && det_en_i && (result_i >= upper_thr_i); // RULE6 RULE7
        lower_set  = conv_valid_i && det_en_i && (result_i <= lower_thr_i); // RULE5 RULE7
        // back inside the band by the hysteresis margin
        upper_back = conv_valid_i && auto_clr_i
                     && (result_i < saf_sat_sub(upper_thr_i, hyst_i)); // RULE9
        lower_back = conv_valid_i && auto_clr_i
                     && (result_i > saf_sat_add(lower_thr_i, hyst_i)); // RULE9
        upper_d = upper_q;
        lower_d = lower_q;
        if (rd_clr_i || upper_back) begin
            upper_d = 1'b0; // RULE8
        end
        if (rd_clr_i || lower_back) begin
            lower_d = 1'b0; // RULE8
        end
        if (upper_set) begin
            upper_d = 1'b1; // RULE12
        end
        if (lower_set) begin
            lower_d = 1'b1; // RULE12
        end
    end

    // ------------------------------------------------------------------------
    // flag registers
    // ------------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            upper_q <= 1'b0; // RULE10
            lower_q <= 1'b0; // RULE10
        end else begin
            upper_q <= upper_d;
            lower_q <= lower_d;
        end
    end

    assign upper_o = upper_q;
    assign lower_o = lower_q;

endmodule : saf_chan_alert

//--- saf_status_alert_monitor.sv
// assertions and covers on the ports of the status and alert flag bank
`timescale 1ns/1ps
module saf_status_alert_monitor (
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic        rd_en_i,
    input wire logic [15:0] rd_addr_i,
    input wire logic [7:0]  iface_err_i,
    input wire logic [15:0] per_input_overvoltage_flag_i,
    input wire logic [23:0] ext_alert_i,
    input wire logic [7:0]  rd_data_o,
    input wire logic        rd_valid_o,
    input wire logic [7:0]  status_o,
    input wire logic [7:0]  alert_flags_ch0_to_3_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wire logic rd_st = rd_en_i && rd_addr_i == 16'h0014;
    wire logic rd_al = rd_en_i && rd_addr_i == 16'h0015;
    wire logic any_ov = |per_input_overvoltage_flag_i;
    read_answer_a: assert property (rd_en_i |=> rd_valid_o)
        else $error("read not answered");
    alert_read_a: assert property (rd_al |=> rd_data_o == $past(alert_flags_ch0_to_3_o))
        else $error("alert read data wrong");
    unmapped_zero_a: assert property (rd_en_i && !rd_st && !rd_al |=> rd_data_o == 8'h00)
        else $error("unmapped read not zero");
    iferr_or_a: assert property ($past(rst_n_i) |-> status_o[2] == |$past(iface_err_i))
        else $error("interface error summary wrong");
    clamp_set_a: assert property ($past(rst_n_i) && $past(any_ov) |-> status_o[1])
        else $error("clamp summary not set");
    clamp_clear_a: assert property (rd_st && !any_ov ##1 rd_st && !any_ov |=> !rd_data_o[1])
        else $error("clamp summary not cleared");
    tda_follow_a: assert property ($past(rst_n_i) |-> status_o[3] ==
        (|$past(alert_flags_ch0_to_3_o) || |$past(ext_alert_i)))
        else $error("alert summary wrong");
    reserved_zero_a: assert property (status_o[7:4] == 4'h0 && !status_o[0])
        else $error("unused status bits set");
    cover property (rd_al && alert_flags_ch0_to_3_o != 8'h00);
    cover property (rd_st && !any_ov ##1 rd_st && !any_ov);
    cover property (status_o[1] && status_o[3]);
endmodule : saf_status_alert_monitor

bind saf_status_alert saf_status_alert_monitor u_mon (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .rd_en_i(rd_en_i), .rd_addr_i(rd_addr_i), .iface_err_i(iface_err_i),
    .per_input_overvoltage_flag_i(per_input_overvoltage_flag_i), .ext_alert_i(ext_alert_i),
    .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .status_o(status_o),
    .alert_flags_ch0_to_3_o(alert_flags_ch0_to_3_o));

//--- saf_host_model.sv
// host side read requester for the status and alert flag bank
`timescale 1ns/1ps
module saf_host_model (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        rd_go_i,
    input  wire logic [15:0] rd_sel_i,
    output logic             rd_en_o,
    output logic [15:0]      rd_addr_o
);
    always_ff @(posedge clk_i) begin
        rd_en_o   <= rd_go_i && rst_n_i;
        // address not held between reads
        rd_addr_o <= rd_go_i ? rd_sel_i : ~rd_addr_o;
    end
endmodule : saf_host_model

//--- tb_saf.sv
// self-checking bench of the status and alert flag bank
`timescale 1ns/1ps
module tb import saf_pkg::*; ;
    logic clk_i = 0, rst_n_i = 0, go = 0, cv = 0, ac = 0;
    logic [15:0] sel = 0, ov = 0;
    logic [7:0]  ie = 0, ma = 0, ms = 0, sn;
    logic [23:0] ea = 0;
    logic [3:0]  ch = 0, de = 0;
    logic        mc = 0;
    logic        pv = 0;
    saf_word_t   res = 0, up [4], lo [4], hy [4];
    logic [7:0]  q [$];
    wire logic        rd_en, rv;
    wire logic [15:0] rd_addr;
    wire logic [7:0]  rdata, st, af;
    int mismatches = 0, num_checks = 0, cyc = 0, seed = 32'hD1E9;
    always #5 clk_i = ~clk_i;
    saf_host_model host (.clk_i(clk_i), .rst_n_i(rst_n_i), .rd_go_i(go), .rd_sel_i(sel),
        .rd_en_o(rd_en), .rd_addr_o(rd_addr));
    saf_status_alert dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .rd_en_i(rd_en),
        .rd_addr_i(rd_addr), .iface_err_i(ie), .per_input_overvoltage_flag_i(ov),
        .ext_alert_i(ea), .conv_valid_i(cv), .conv_ch_i(ch), .conv_result_i(res),
        .upper_thr_i(up), .lower_thr_i(lo), .hyst_i(hy), .det_en_i(de),
        .alert_auto_clr_i(ac), .rd_data_o(rdata), .rd_valid_o(rv), .status_o(st),
        .alert_flags_ch0_to_3_o(af));
    task check(input string n, input logic [7:0] s, input logic [7:0] e);
        num_checks++;
        if (s !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task end_sim;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim
    // ------------------------------------------------------------------
    // reference model, compared every cycle after the second and at every read result
    // ------------------------------------------------------------------
    always @(posedge clk_i) begin : model
        logic [7:0] n;
        int c, r;
        cyc++;
        if (cyc > 2500) begin
            mismatches++;
            end_sim();
        end
        if (cyc > 2) check("alert_flags", af, ma);
        if (cyc > 2) check("status", st, ms);
        if (rv) check("rd_data", rdata, q.size() > 0 ? q.pop_front() : 8'h5A);
        if (cyc > 2) check("rd_valid", {7'h00, rv}, {7'h00, pv});
        sn = {4'h0, ma != 8'h00 || |ea, |ie, mc || |ov, 1'b0};
        if (!rst_n_i) begin
            ma = 8'h00;
            mc = 0;
            ms = 8'h00;
            q.delete();
            pv = 0;
        end else begin
            if (rd_en) q.push_back(rd_addr == 16'h0014 ? sn : rd_addr == 16'h0015 ? ma : 8'h00);
            n = (rd_en && rd_addr == 16'h0015) ? 8'h00 : ma;
            if (cv && ch < 4) begin
                c = ch;
                r = res;
                if (ac && r < int'(up[c]) - int'(hy[c])) n[2*c] = 0;
                if (ac && r > int'(lo[c]) + int'(hy[c])) n[2*c+1] = 0;
                if (de[c] && r >= up[c]) n[2*c] = 1;
                if (de[c] && r <= lo[c]) n[2*c+1] = 1;
            end
            mc = |ov || (mc && !(rd_en && rd_addr == 16'h0014));
            ma = n;
            ms = sn;
            pv = rd_en;
        end
    end
    // ------------------------------------------------------------------
    // random traffic in four phases of detect enable and auto-clear
    // ------------------------------------------------------------------
    initial begin
        logic [31:0] k;
        for (int i = 0; i < 4; i++) begin
            up[i] = 16'hC000 + 16'(i * 16'h0100);
            lo[i] = 16'h4000 - 16'(i * 16'h0100);
            hy[i] = 16'h1000;
        end
        repeat (20) @(posedge clk_i);
        rst_n_i <= 1;
        for (int p = 0; p < 4; p++) begin
            if (p == 2) begin
                rst_n_i <= 0;
                repeat (3) @(posedge clk_i);
                rst_n_i <= 1;
            end
            de <= (p == 0) ? 4'h0 : 4'hF;
            ac <= p[0];
            repeat (500) begin
                @(posedge clk_i);
                k = $random(seed);
                go  <= k[0] | k[1];
                sel <= (k[3:2] == 0) ? 16'($random(seed)) : 16'h0014 + 16'(k[4]);
                cv  <= k[5];
                ch  <= {1'b0, k[8:6]};
                res <= (k[10:9] == 0) ? up[k[7:6]] : (k[10:9] == 1) ? lo[k[7:6]] : k[31:16];
                ie  <= (k[13:11] == 0) ? 8'h01 << k[15:14] : 8'h00;
                ov  <= (k[13:11] == 7) ? 16'h0001 << k[19:16] : 16'h0000;
                ea  <= (k[22:20] == 7) ? 24'h000001 << k[27:23] : 24'h000000;
                // mixed per-channel detection enables in the last phase
                if (p == 3) de <= k[31:28];
            end
        end
        repeat (5) @(posedge clk_i);
        end_sim();
    end
endmodule : tb
